// ### pkg/dtc_pkg.sv
// constants, types and field layout of the dual timer / event counter
// assumes a 250 MHz cpu clock and word-aligned avalon register slots
package dtc_pkg;

  // cpu clocks per machine cycle
  localparam int unsigned MC_CLKS   = 6;
  localparam int unsigned PRE_W     = 3;
  localparam logic [2:0]  MC_LAST   = 3'(MC_CLKS - 1);

  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CTRL  = 8'h88;
  localparam logic [7:0]  IDX_MODE  = 8'h89;
  localparam logic [7:0]  IDX_LO0   = 8'h8a;
  localparam logic [7:0]  IDX_LO1   = 8'h8b;
  localparam logic [7:0]  IDX_HI0   = 8'h8c;
  localparam logic [7:0]  IDX_HI1   = 8'h8d;
  localparam logic [7:0]  IDX_OPT   = 8'h8e;
  localparam int unsigned ADDR_W    = 10;

  // reset values
  localparam logic [7:0]  MODE_RST  = 8'h00;
  localparam logic [7:0]  CNT_RST   = 8'h00;

  // timer_mode_config fields; bits 7:6 are reserved and read zero
  localparam int unsigned MF0_LSB   = 0;
  localparam int unsigned CT_BIT    = 2;
  localparam int unsigned GATE_BIT  = 3;
  localparam int unsigned MF1_LSB   = 4;
  localparam logic [7:0]  MODE_MASK = 8'h3f;

  // control register: run and overflow bits
  localparam int unsigned TR0_BIT   = 4;
  localparam int unsigned TF0_BIT   = 5;
  localparam int unsigned TR1_BIT   = 6;
  localparam int unsigned TF1_BIT   = 7;

  // option register: toggle enable and synchronised pin level
  localparam int unsigned TOG_BIT   = 0;
  localparam int unsigned PINL_BIT  = 1;

  typedef enum logic [1:0] {
    DTC_M13,
    DTC_M16,
    DTC_M8R,
    DTC_MSPLIT
  } dtc_mode_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } dtc_cnt_t;

  typedef struct packed {
    logic     ovf;
    dtc_cnt_t cnt;
  } dtc_step_t;

endpackage : dtc_pkg

// ### design/dtc_edge_sampler.sv
// pin synchroniser with once-per-machine-cycle sampling and fall detect
// assumes i_sample is a one-cycle strobe on the same clock
`timescale 1ns/1ns
module dtc_edge_sampler
  import dtc_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_arst_n,
  input  wire logic i_clk_en,
  input  wire logic i_pin,
  input  wire logic i_sample,
  output logic      o_level,
  output logic      o_fall
);

  typedef struct packed {
    logic [1:0] sync;
    logic       samp;
    logic       fall;
  } dtc_smp_st_t;

  dtc_smp_st_t s_q;
  dtc_smp_st_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.sync = {s_q.sync[0], i_pin};
    s_d.fall = 1'b0;
    // relies on levels held a full machine cycle
    if (i_sample) begin
      s_d.samp = s_q.sync[1];
      s_d.fall = s_q.samp & ~s_q.sync[1];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
    end else if (i_clk_en) begin
      s_q <= s_d;
    end
  end

  assign o_level = s_q.sync[1];
  assign o_fall  = s_q.fall;

  a_fall_cause: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $rose(s_q.fall) |-> $past(i_sample) && $past(s_q.samp))
    else $error("fall flagged without high then low samples");

endmodule : dtc_edge_sampler

// ### design/dtc_timer.sv
// two up-counters, timer 0 timer or event counter, timer 1 timer only, with avalon-mm registers
// assumes a synchronous avalon master on i_sys_clk; pins are asynchronous
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ns
module dtc_timer
  import dtc_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_arst_n,
  input  wire logic              i_clk_en,
  input  wire logic [ADDR_W-1:0] i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic      [31:0]       o_avs_readdata,
  output logic                   o_avs_waitrequest,
  input  wire logic              i_count_input_pin,
  output logic                   o_count_input_pin,
  output logic                   o_count_input_pin_oe_n,
  input  wire logic              i_external_interrupt_zero_pin,
  output logic                   o_overflow_flag0,
  output logic                   o_overflow_flag1
);

  typedef struct packed {
    logic             wreq;
    logic [31:0]      rdata;
    logic [7:0]       mode;
    logic             tr0;
    logic             tr1;
    logic             tf0;
    logic             tf1;
    logic             tog_en;
    logic             pin_out;
    dtc_cnt_t         c0;
    dtc_cnt_t         c1;
    logic [PRE_W-1:0] pre;
    logic             pend;
  } dtc_st_t;

  dtc_st_t s_q;
  dtc_st_t s_d;

  logic       pin_lvl;
  logic       pin_fall;
  logic       external_interrupt_zero_pin_lvl;
  logic       mc;
  logic       wr_fire;
  logic [7:0] idx;
  logic       hit;
  logic       t0_en;
  logic       t0_tick;
  logic       ovf0;
  dtc_step_t  st0;
  dtc_step_t  st1;
  dtc_mode_t  m0;
  dtc_mode_t  m1;
  logic [8:0] hi0_inc;

  // per-mode increment, shared by both timers
  function automatic dtc_step_t dtc_step(input dtc_mode_t m,
                                         input dtc_cnt_t  c);
    logic [5:0]  lo6;
    logic [8:0]  h9;
    logic [8:0]  l9;
    logic [16:0] w17;
    dtc_step_t   r;
    lo6 = {1'b0, c.lo[4:0]} + 6'h01;
    h9  = {1'b0, c.hi} + {8'h00, lo6[5]};
    l9  = {1'b0, c.lo} + 9'h001;
    w17 = {1'b0, c} + 17'h00001;
    r   = '{ovf: 1'b0, cnt: c};
    case (m)
      DTC_M13: r = '{ovf: h9[8], cnt: '{hi: h9[7:0],
                                        lo: {c.lo[7:5], lo6[4:0]}}};
      DTC_M16: r = '{ovf: w17[16], cnt: w17[15:0]};
      DTC_M8R: r = '{ovf: l9[8], cnt: '{hi: c.hi,
                                        lo: l9[8] ? c.hi : l9[7:0]}};
      DTC_MSPLIT: r = '{ovf: l9[8], cnt: '{hi: c.hi, lo: l9[7:0]}};
      default: r = '{ovf: 1'b0, cnt: c};
    endcase
    return r;
  endfunction : dtc_step

  dtc_edge_sampler u_pin_smp (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_clk_en  (i_clk_en),
    .i_pin     (i_count_input_pin),
    .i_sample  (mc),
    .o_level   (pin_lvl),
    .o_fall    (pin_fall)
  );

  dtc_edge_sampler u_external_interrupt_zero_pin_smp (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_clk_en  (i_clk_en),
    .i_pin     (i_external_interrupt_zero_pin),
    .i_sample  (mc),
    .o_level   (external_interrupt_zero_pin_lvl),
    .o_fall    ()
  );

  assign idx     = i_avs_address[ADDR_W-1:2];
  assign hit     = (i_avs_address[1:0] == 2'b00);
  assign wr_fire = i_avs_write & ~s_q.wreq & hit & i_avs_byteenable[0];
  assign mc      = (s_q.pre == MC_LAST);
  assign m0      = dtc_mode_t'(s_q.mode[MF0_LSB +: 2]);
  assign m1      = dtc_mode_t'(s_q.mode[MF1_LSB +: 2]);
  assign t0_en   = s_q.tr0 & (~s_q.mode[GATE_BIT] | external_interrupt_zero_pin_lvl);
  assign t0_tick = t0_en & mc & (~s_q.mode[CT_BIT] | s_q.pend);
  assign st0     = dtc_step(m0, s_q.c0);
  assign st1     = dtc_step(m1, s_q.c1);
  assign hi0_inc = {1'b0, s_q.c0.hi} + 9'h001;
  assign ovf0    = t0_tick & st0.ovf;

  always_comb begin
    s_d = s_q;
    s_d.pre = mc ? '0 : s_q.pre + 3'(1);
    // edge counted at the next machine cycle
    s_d.pend = pin_fall | (s_q.pend & ~mc);
    if (t0_tick) begin
      s_d.c0 = st0.cnt;
    end
    if (m0 == DTC_MSPLIT) begin
      // high byte on timer 1 run bit, timer 1 held
      if (s_q.tr1 & mc) begin
        s_d.c0.hi = hi0_inc[7:0];
      end
    end else if (s_q.tr1 & mc) begin
      s_d.c1 = st1.cnt;
    end
    if (ovf0 & s_q.tog_en) begin
      s_d.pin_out = ~s_q.pin_out;
    end
    // bus: one wait cycle, then the access completes
    if ((i_avs_read | i_avs_write) & s_q.wreq) begin
      s_d.wreq  = 1'b0;
      s_d.rdata = '0;
      if (hit) begin
        case (idx)
          IDX_CTRL: s_d.rdata[7:0] = {s_q.tf1, s_q.tr1, s_q.tf0, s_q.tr0,
                                      4'h0};
          IDX_MODE: s_d.rdata[7:0] = s_q.mode & MODE_MASK;
          IDX_LO0:  s_d.rdata[7:0] = s_q.c0.lo;
          IDX_LO1:  s_d.rdata[7:0] = s_q.c1.lo;
          IDX_HI0:  s_d.rdata[7:0] = s_q.c0.hi;
          IDX_HI1:  s_d.rdata[7:0] = s_q.c1.hi;
          IDX_OPT:  s_d.rdata[PINL_BIT:TOG_BIT] = {pin_lvl, s_q.tog_en};
          default:  s_d.rdata = '0;
        endcase
      end
    end else if (~s_q.wreq) begin
      s_d.wreq = 1'b1;
    end
    // run bit write leaves counts alone; bus write beats counting
    if (wr_fire) begin
      case (idx)
        IDX_CTRL: begin
          s_d.tr0 = i_avs_writedata[TR0_BIT];
          s_d.tr1 = i_avs_writedata[TR1_BIT];
          s_d.tf0 = i_avs_writedata[TF0_BIT];
          s_d.tf1 = i_avs_writedata[TF1_BIT];
        end
        IDX_MODE: s_d.mode  = i_avs_writedata[7:0] & MODE_MASK;
        IDX_LO0:  s_d.c0.lo = i_avs_writedata[7:0];
        IDX_LO1:  s_d.c1.lo = i_avs_writedata[7:0];
        IDX_HI0:  s_d.c0.hi = i_avs_writedata[7:0];
        IDX_HI1:  s_d.c1.hi = i_avs_writedata[7:0];
        IDX_OPT:  s_d.tog_en = i_avs_writedata[TOG_BIT];
        default:  s_d.tog_en = s_q.tog_en;
      endcase
    end
    // overflow sets flag; set wins over a clearing write
    if (ovf0) begin
      s_d.tf0 = 1'b1;
    end
    if (m0 == DTC_MSPLIT) begin
      if (s_q.tr1 & mc & hi0_inc[8]) begin
        s_d.tf1 = 1'b1;
      end
    end else if (s_q.tr1 & mc & st1.ovf) begin
      s_d.tf1 = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q       <= '0;
      s_q.wreq  <= 1'b1;
      s_q.mode  <= MODE_RST;
      s_q.c0    <= {CNT_RST, CNT_RST};
      s_q.c1    <= {CNT_RST, CNT_RST};
    end else if (i_clk_en) begin
      s_q <= s_d;
    end
  end

  assign o_avs_readdata         = s_q.rdata;
  assign o_avs_waitrequest      = s_q.wreq;
  assign o_count_input_pin      = s_q.pin_out;
  assign o_count_input_pin_oe_n = ~s_q.tog_en;
  assign o_overflow_flag0       = s_q.tf0;
  assign o_overflow_flag1       = s_q.tf1;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n || !i_clk_en);

  a_mc_period: assert property (mc |=> !mc [*5] ##1 mc)
    else $error("machine cycle strobe not every six clocks");
  a_timer_step: assert property (t0_tick && m0 == DTC_M16 && !wr_fire
    |=> s_q.c0 == $past(s_q.c0) + 16'h0001)
    else $error("timer 0 did not step by one");
  a_idle_hold: assert property (!mc && !wr_fire |=> s_q.c1 == $past(s_q.c1))
    else $error("timer 1 moved off a machine cycle");
  a_edge_pend: assert property (pin_fall |=> s_q.pend)
    else $error("detected edge not held for next cycle");
  a_counter_src: assert property (s_q.mode[CT_BIT] && !s_q.pend && mc
    && !wr_fire |=> s_q.c0.lo == $past(s_q.c0.lo))
    else $error("counter moved without a pin edge");
  a_mode0_wrap: assert property (t0_tick && m0 == DTC_M13 && !wr_fire
    && s_q.c0.hi == 8'hff && s_q.c0.lo[4:0] == 5'h1f
    |=> s_q.tf0 && s_q.c0.hi == 8'h00 && s_q.c0.lo[4:0] == 5'h00)
    else $error("thirteen-bit wrap wrong");
  a_gate_block: assert property (s_q.mode[GATE_BIT] && !external_interrupt_zero_pin_lvl
    && !wr_fire |=> s_q.c0.lo == $past(s_q.c0.lo))
    else $error("gated timer 0 counted");
  a_run_keeps: assert property ($rose(s_q.tr0)
    |-> s_q.c0 == $past(s_q.c0))
    else $error("setting run changed count");
  a_reload: assert property (t0_tick && m0 == DTC_M8R && !wr_fire
    && s_q.c0.lo == 8'hff |=> s_q.c0.lo == $past(s_q.c0.hi) && s_q.tf0)
    else $error("auto reload wrong");
  a_split_stop: assert property (m0 == DTC_MSPLIT && !wr_fire
    |=> s_q.c1 == $past(s_q.c1))
    else $error("timer 1 ran in split mode");
  a_pin_toggle: assert property (ovf0 && s_q.tog_en
    |=> o_count_input_pin != $past(o_count_input_pin))
    else $error("pin not toggled on overflow");
  a_bus_answer: assert property ((i_avs_read || i_avs_write) && s_q.wreq
    |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not one cycle later");

  c_mode0_ovf: cover property (t0_tick && m0 == DTC_M13 && st0.ovf);
  c_edge_cnt: cover property (t0_tick && s_q.mode[CT_BIT]);
  c_reload: cover property (t0_tick && m0 == DTC_M8R && st0.ovf);
  c_toggle: cover property (ovf0 && s_q.tog_en);

endmodule : dtc_timer

// ### verification/dtc_pin_src.sv
// far-side model: count pin source and gate pin driver
// assumes the bench clock; levels change just after a rising edge
`timescale 1ns/1ns
module dtc_pin_src (
  input  wire logic i_sys_clk,
  output logic      o_pin,
  output logic      o_gate
);
  initial begin
    o_pin  = 1'b1;
    o_gate = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : hold

  // each level held at least one machine cycle
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge i_sys_clk);
      o_pin <= 1'b0;
      hold($urandom_range(12, 6));
      o_pin <= 1'b1;
      hold($urandom_range(12, 6));
    end
  endtask : pulses

  task automatic gate(input logic v);
    @(posedge i_sys_clk);
    o_gate <= v;
  endtask : gate
endmodule : dtc_pin_src

// ### verification/dual_timer_event_counter_test.sv
// self-checking bench for the dual timer / event counter
// assumes the design's avalon slave answers one cycle after a request
`timescale 1ns/1ns
module dual_timer_event_counter_test
  import dtc_pkg::*;
();
  logic              sys_clk   = 1'b0;
  logic              arst_n    = 1'b0;
  logic [ADDR_W-1:0] address   = '0;
  logic              read      = 1'b0;
  logic              write     = 1'b0;
  logic [31:0]       writedata = '0;
  logic [3:0]        be        = 4'h1;
  logic              clk_en    = 1'b1;
  logic [31:0]       readdata;
  logic              waitrequest, pin_out, pin_oe_n, flag0, flag1;
  logic              src_pin, gate_pin;
  wire               pin_wire;
  int                err_total   = 0;
  int                comparisons = 0;
  int                n;
  logic [15:0]       exp_q[$];
  logic [15:0]       exp_e;

  // the design only owns the pin while its output enable is low
  assign pin_wire = pin_oe_n ? src_pin : pin_out;
  always #2 sys_clk = ~sys_clk;

  dtc_timer dtc_timer_i (
    .i_sys_clk                     (sys_clk),
    .i_arst_n                      (arst_n),
    .i_clk_en                      (clk_en),
    .i_avs_address                 (address),
    .i_avs_read                    (read),
    .i_avs_write                   (write),
    .i_avs_writedata               (writedata),
    .i_avs_byteenable              (be),
    .o_avs_readdata                (readdata),
    .o_avs_waitrequest             (waitrequest),
    .i_count_input_pin             (pin_wire),
    .o_count_input_pin             (pin_out),
    .o_count_input_pin_oe_n        (pin_oe_n),
    .i_external_interrupt_zero_pin (gate_pin),
    .o_overflow_flag0              (flag0),
    .o_overflow_flag1              (flag1)
  );

  dtc_pin_src dtc_pin_src_i (
    .i_sys_clk (sys_clk),
    .o_pin     (src_pin),
    .o_gate    (gate_pin)
  );

  task automatic finish_test;
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  // e holds expected byte (high half) and compare mask (low half)
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d, input logic [7:0] m);
    int k;
    k = 0;
    @(posedge sys_clk);
    address   <= {idx, 2'b00};
    read      <= !wr;
    write     <= wr;
    writedata <= {24'h0, d};
    if (!wr) exp_q.push_back({d, m});
    do begin
      @(posedge sys_clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 100);
    read  <= 1'b0;
    write <= 1'b0;
    if (k >= 100) begin
      err_total++;
      $display("mismatch %0t bus hang", $time);
    end
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 8'h00);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] e,
                    input logic [7:0] m);
    bus(1'b0, idx, e, m);
  endtask : rd

  task automatic chk(input logic got, input logic e);
    comparisons++;
    if (got !== e) begin
      err_total++;
      $display("mismatch %0t pin or flag is %b", $time, got);
    end
  endtask : chk

  task automatic arm(input logic [7:0] m, input int t, input logic [7:0] h,
                     input logic [7:0] l, input logic [7:0] run);
    wr(IDX_MODE, m);
    wr(IDX_CTRL, 8'h00);
    wr(IDX_HI0 + 8'(t), h);
    wr(IDX_LO0 + 8'(t), l);
    wr(IDX_CTRL, run);
  endtask : arm

  always @(posedge sys_clk) begin
    if (read && waitrequest === 1'b0 && exp_q.size() > 0) begin
      exp_e = exp_q.pop_front();
      comparisons++;
      if ({readdata[31:8], readdata[7:0] & exp_e[7:0]}
          !== {24'h0, exp_e[15:8] & exp_e[7:0]}) begin
        err_total++;
        $display("mismatch %0t read %h", $time, readdata);
      end
    end
  end

  initial begin
    #80000;
    err_total++;
    $display("mismatch %0t run timed out", $time);
    finish_test();
  end

  initial begin
    void'($urandom(57431));
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int i = 8'h88; i < 8'h8e; i++) rd(8'(i), MODE_RST, 8'hff);
    rd(IDX_OPT, 8'h02, 8'h03);
    rd(8'h90, 8'h00, 8'hff);
    chk(pin_oe_n, 1'b1);
    wr(IDX_MODE, 8'hff);
    rd(IDX_MODE, MODE_MASK, 8'hff);
    be <= 4'h0;
    wr(IDX_MODE, 8'h00);
    be <= 4'h1;
    rd(IDX_MODE, MODE_MASK, 8'hff);
    arm(8'h00, 0, 8'hff, 8'h1e, 8'h10);
    chk(flag0, 1'b0);
    repeat (20) @(posedge sys_clk);
    chk(flag0, 1'b1);
    wr(IDX_CTRL, 8'h00);
    rd(IDX_HI0, 8'h00, 8'hff);
    rd(IDX_LO0, 8'h00, 8'h1c);
    arm(8'h02, 0, 8'ha0, 8'hfd, 8'h10);
    repeat (24) @(posedge sys_clk);
    chk(flag0, 1'b1);
    wr(IDX_CTRL, 8'h00);
    rd(IDX_LO0, 8'ha0, 8'hfc);
    rd(IDX_HI0, 8'ha0, 8'hff);
    wr(IDX_OPT, 8'h01);
    arm(8'h01, 0, 8'hff, 8'hf0, 8'h10);
    chk(pin_oe_n, 1'b0);
    chk(pin_out, 1'b0);
    repeat (84) @(posedge sys_clk);
    chk(flag0, 1'b0);
    repeat (20) @(posedge sys_clk);
    chk(flag0, 1'b1);
    chk(pin_out, 1'b1);
    wr(IDX_OPT, 8'h00);
    n = $urandom_range(9, 3);
    arm(8'h05, 0, 8'h00, 8'h00, 8'h10);
    dtc_pin_src_i.pulses(n);
    repeat (30) @(posedge sys_clk);
    rd(IDX_LO0, 8'(n), 8'hff);
    wr(IDX_MODE, 8'h0d);
    dtc_pin_src_i.gate(1'b0);
    dtc_pin_src_i.pulses(4);
    repeat (30) @(posedge sys_clk);
    rd(IDX_LO0, 8'(n), 8'hff);
    dtc_pin_src_i.gate(1'b1);
    repeat (4) @(posedge sys_clk);
    dtc_pin_src_i.pulses(2);
    repeat (30) @(posedge sys_clk);
    rd(IDX_LO0, 8'(n + 2), 8'hff);
    arm(8'h13, 0, 8'hfe, 8'h00, 8'h00);
    wr(IDX_LO1, 8'h55);
    wr(IDX_CTRL, 8'h40);
    repeat (30) @(posedge sys_clk);
    chk(flag1, 1'b1);
    chk(flag0, 1'b0);
    rd(IDX_LO1, 8'h55, 8'hff);
    arm(8'h10, 1, 8'hff, 8'hfe, 8'h40);
    // low enable freezes the running timer before its first tick
    clk_en <= 1'b0;
    repeat (30) @(posedge sys_clk);
    chk(flag1, 1'b0);
    clk_en <= 1'b1;
    repeat (30) @(posedge sys_clk);
    chk(flag1, 1'b1);
    finish_test();
  end
endmodule : dual_timer_event_counter_test
